// ===== rtl/clock_ctrl.sv
// PLL control, main clock selection and oscillator control registers.
`timescale 1ns/1ps
`include "clkctl_params.svh"
module clock_ctrl (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire clkctl_pkg::reg_req_t req_i,
  output logic [7:0] rd_data_o,
  input wire logic hoco_tick_i,
  input wire logic oco_tick_i,
  input wire logic mx_tick_i,
  input wire logic pll_osc_tick_i,
  input wire logic wdt_active_i,
  output logic hoco_run_o,
  output logic moco_run_o,
  output logic loco_run_o,
  output logic pll_run_o,
  output logic pll_ref_tick_o,
  output logic pll_factor_ok_o,
  output logic pll_lock_wait_o,
  output logic pll_tick_o,
  output logic main_tick_o,
  output logic main_on_pll_o,
  output logic dsad_tick_o,
  output clkctl_pkg::osc_mode_t main_osc_mode_o,
  output clkctl_pkg::osc_mode_t sub_osc_mode_o
);
  import clkctl_pkg::*;

  ctl_state_t st_ff;
  ctl_state_t nxt_st;
  logic want_pll;
  logic base_tick;
  logic hoco_live;
  logic pll_ref_src;
  logic sw_on_pll;
  logic [7:0] rd_word;

  // The oscillator only ticks into this block while it is not halted.
  assign hoco_live = hoco_tick_i & ~st_ff.hoco_halt;
  assign pll_ref_src = hoco_live & st_ff.pll_in_gate;

  // A set main-select bit forces the non-PLL path; this keeps the CPU on
  // the system clock even if software left the source select at 1.
  assign want_pll = st_ff.src_sel & ~st_ff.sys_main_sel;
  assign base_tick = st_ff.sys_main_sel ? mx_tick_i : oco_tick_i;

  always_comb begin
    rd_word = 8'h00;
    case (req_i.addr)
      `CC_OFS_PLL_CTRL: begin
        rd_word[`CC_BIT_PLL_RUN] = st_ff.pll_run;
        rd_word[`CC_BIT_PLL_MULT] = st_ff.pll_mult;
        rd_word[`CC_BIT_PLL_DIV_HI:`CC_BIT_PLL_DIV_LO] = st_ff.pll_div;
      end
      `CC_OFS_MAIN_CTRL: begin
        rd_word[`CC_BIT_SRC_SEL] = st_ff.src_sel;
        rd_word[`CC_BIT_SW_STATE] = sw_on_pll;
      end
      `CC_OFS_PERIPH_GATE: begin
        rd_word[`CC_BIT_DSAD_SEL] = st_ff.dsad_sel;
        rd_word[`CC_BIT_PLL_GATE] = st_ff.pll_in_gate;
      end
      `CC_OFS_SYS_CTRL: begin
        rd_word[`CC_BIT_SYS_MAIN] = st_ff.sys_main_sel;
      end
      `CC_OFS_MODE_CTRL: begin
        rd_word[`CC_BIT_MAIN_EXT] = st_ff.main_ext;
        rd_word[`CC_BIT_MAIN_PIN] = st_ff.main_pin;
        rd_word[`CC_BIT_SUB_PATH] = st_ff.sub_path;
      end
      `CC_OFS_SUB_MODE: begin
        rd_word[`CC_BIT_SUB_EXT] = st_ff.sub_ext;
        rd_word[`CC_BIT_SUB_PIN] = st_ff.sub_pin;
      end
      `CC_OFS_OSC_STATUS: begin
        rd_word[`CC_BIT_HOCO_HALT] = st_ff.hoco_halt;
        rd_word[`CC_BIT_MOCO_EN] = st_ff.moco_en;
      end
      `CC_OFS_SUPPLY_MODE: begin
        rd_word[`CC_BIT_LT_SRC] = st_ff.lt_src;
      end
      `CC_OFS_SUBSYS_SEL: begin
        rd_word[`CC_BIT_LS_SEL] = st_ff.ls_sel;
      end
      default: begin
        rd_word = 8'h00;
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_data = req_i.rd ? rd_word : 8'h00;
    if (req_i.wr) begin
      case (req_i.addr)
        // Reserved bits are dropped, so they always read back as zero.
        `CC_OFS_PLL_CTRL: begin
          nxt_st.pll_run = req_i.wdata[`CC_BIT_PLL_RUN];
          nxt_st.pll_mult = req_i.wdata[`CC_BIT_PLL_MULT];
          nxt_st.pll_div =
            req_i.wdata[`CC_BIT_PLL_DIV_HI:`CC_BIT_PLL_DIV_LO];
        end
        `CC_OFS_MAIN_CTRL: begin
          nxt_st.src_sel = req_i.wdata[`CC_BIT_SRC_SEL];
        end
        `CC_OFS_PERIPH_GATE: begin
          nxt_st.dsad_sel = req_i.wdata[`CC_BIT_DSAD_SEL];
          nxt_st.pll_in_gate = req_i.wdata[`CC_BIT_PLL_GATE];
        end
        `CC_OFS_SYS_CTRL: begin
          nxt_st.sys_main_sel = req_i.wdata[`CC_BIT_SYS_MAIN];
        end
        `CC_OFS_MODE_CTRL: begin
          nxt_st.main_ext = req_i.wdata[`CC_BIT_MAIN_EXT];
          nxt_st.main_pin = req_i.wdata[`CC_BIT_MAIN_PIN];
          nxt_st.sub_path = req_i.wdata[`CC_BIT_SUB_PATH];
        end
        `CC_OFS_SUB_MODE: begin
          nxt_st.sub_ext = req_i.wdata[`CC_BIT_SUB_EXT];
          nxt_st.sub_pin = req_i.wdata[`CC_BIT_SUB_PIN];
        end
        `CC_OFS_OSC_STATUS: begin
          nxt_st.hoco_halt = req_i.wdata[`CC_BIT_HOCO_HALT];
          nxt_st.moco_en = req_i.wdata[`CC_BIT_MOCO_EN];
        end
        `CC_OFS_SUPPLY_MODE: begin
          nxt_st.lt_src = req_i.wdata[`CC_BIT_LT_SRC];
        end
        `CC_OFS_SUBSYS_SEL: begin
          nxt_st.ls_sel = req_i.wdata[`CC_BIT_LS_SEL];
        end
        default: begin
          nxt_st.src_sel = st_ff.src_sel;
        end
      endcase
    end

    // Reference divider: one pulse out for every sixth gated input tick.
    // The divider is held clear while the PLL is stopped so a restart
    // always begins a whole reference period.
    nxt_st.ref_tick = 1'b0;
    if (!st_ff.pll_run) begin
      nxt_st.ref_cnt = 3'h0;
    end else if (pll_ref_src) begin
      if (st_ff.ref_cnt == `CC_PLL_REF_DIV - 3'h1) begin
        nxt_st.ref_cnt = 3'h0;
        nxt_st.ref_tick = 1'b1;
      end else begin
        nxt_st.ref_cnt = st_ff.ref_cnt + 3'h1;
      end
    end

    // The analog loop ticks only while running, fed and correctly set.
    nxt_st.pll_tick = pll_osc_tick_i & st_ff.pll_run & pll_ref_src
      & pll_factor_ok_o;

    // Status only: lock still settling after start; no hardware holdoff.
    if (!st_ff.pll_run) begin
      nxt_st.lock_cnt = 10'h000;
    end else if (st_ff.lock_cnt != 10'(`CC_PLL_LOCK_CYC)) begin
      nxt_st.lock_cnt = st_ff.lock_cnt + 10'h001;
    end

    // Converter clock: halved oscillator or the mx_tick_i source, never the PLL.
    nxt_st.dsad_tick = 1'b0;
    if (st_ff.dsad_sel) begin
      nxt_st.dsad_tick = mx_tick_i;
    end else if (hoco_live) begin
      nxt_st.half_ph = ~st_ff.half_ph;
      nxt_st.dsad_tick = st_ff.half_ph;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  main_clk_switch u_switch (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .want_pll_i(want_pll),
    .base_tick_i(base_tick),
    .pll_tick_i(st_ff.pll_tick),
    .main_tick_o(main_tick_o),
    .on_pll_o(sw_on_pll)
  );

  always_comb begin
    case ({st_ff.main_ext, st_ff.main_pin})
      2'h1: main_osc_mode_o = OSC_RESONATOR;
      2'h3: main_osc_mode_o = OSC_EXT_CLOCK;
      2'h0: main_osc_mode_o = OSC_PORT;
      default: main_osc_mode_o = OSC_UNDEFINED;
    endcase
  end

  always_comb begin
    case ({st_ff.sub_ext, st_ff.sub_pin, st_ff.sub_path})
      3'h3: sub_osc_mode_o = OSC_RESONATOR;
      3'h7: sub_osc_mode_o = OSC_EXT_CLOCK;
      3'h0, 3'h1: sub_osc_mode_o = OSC_PORT;
      default: sub_osc_mode_o = OSC_UNDEFINED;
    endcase
  end

  assign pll_factor_ok_o = st_ff.pll_mult
    & (st_ff.pll_div == `CC_PLL_DIV_BY6);
  assign rd_data_o = st_ff.rd_data;
  assign hoco_run_o = ~st_ff.hoco_halt;
  assign moco_run_o = st_ff.moco_en;
  assign loco_run_o = wdt_active_i | st_ff.lt_src | st_ff.ls_sel;
  assign pll_run_o = st_ff.pll_run;
  assign pll_ref_tick_o = st_ff.ref_tick;
  assign pll_lock_wait_o = st_ff.pll_run
    & (st_ff.lock_cnt != 10'(`CC_PLL_LOCK_CYC));
  assign pll_tick_o = st_ff.pll_tick;
  assign main_on_pll_o = sw_on_pll;
  assign dsad_tick_o = st_ff.dsad_tick;

endmodule // clock_ctrl

// ===== shared/clkctl_params.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef CLKCTL_PARAMS_SVH
`define CLKCTL_PARAMS_SVH

`define CC_ADDR_W 20
`define CC_DATA_W 8

`define CC_OFS_PERIPH_GATE 20'hF0098
`define CC_OFS_PLL_CTRL 20'hF02E5
`define CC_OFS_MAIN_CTRL 20'hF02E6
`define CC_OFS_MODE_CTRL 20'hF00A0
`define CC_OFS_SUB_MODE 20'hF00A1
`define CC_OFS_OSC_STATUS 20'hF00A2
`define CC_OFS_SUBSYS_SEL 20'hF00A3
`define CC_OFS_SYS_CTRL 20'hF00A4
`define CC_OFS_SUPPLY_MODE 20'hF00F3

`define CC_RST_BYTE 8'h00

`define CC_BIT_PLL_RUN 0
`define CC_BIT_PLL_MULT 1
`define CC_BIT_PLL_DIV_LO 2
`define CC_BIT_PLL_DIV_HI 3
`define CC_BIT_SRC_SEL 0
`define CC_BIT_SW_STATE 7
`define CC_BIT_DSAD_SEL 0
`define CC_BIT_PLL_GATE 1
`define CC_BIT_SYS_MAIN 4
`define CC_BIT_MAIN_EXT 7
`define CC_BIT_MAIN_PIN 6
`define CC_BIT_SUB_PATH 4
`define CC_BIT_SUB_EXT 5
`define CC_BIT_SUB_PIN 4
`define CC_BIT_HOCO_HALT 0
`define CC_BIT_MOCO_EN 1
`define CC_BIT_LT_SRC 4
`define CC_BIT_LS_SEL 0

`define CC_PLL_DIV_BY6 2'h3
`define CC_PLL_REF_DIV 3'h6
`define CC_PLL_MUL 5'h10
`define CC_PLL_POST_DIV 2'h2

`define CC_CLK_MHZ 10
`define CC_PLL_LOCK_US 40
`define CC_PLL_LOCK_CYC (`CC_PLL_LOCK_US * `CC_CLK_MHZ)

`endif

// ===== shared/clkctl_pkg.sv
// Types shared by the clock control block and its main clock switch.
package clkctl_pkg;

  typedef enum logic [1:0] {
    OSC_PORT,
    OSC_RESONATOR,
    OSC_EXT_CLOCK,
    OSC_UNDEFINED
  } osc_mode_t;

  typedef enum logic [1:0] {
    SW_RUN,
    SW_DRAIN,
    SW_WAIT_NEW
  } sw_phase_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    sw_phase_t phase;
    logic on_pll;
    logic want_pll;
    logic tick;
  } sw_state_t;

  typedef struct packed {
    logic pll_run;
    logic pll_mult;
    logic [1:0] pll_div;
    logic src_sel;
    logic pll_in_gate;
    logic dsad_sel;
    logic sys_main_sel;
    logic main_ext;
    logic main_pin;
    logic sub_path;
    logic sub_ext;
    logic sub_pin;
    logic hoco_halt;
    logic moco_en;
    logic lt_src;
    logic ls_sel;
    logic [2:0] ref_cnt;
    logic ref_tick;
    logic half_ph;
    logic dsad_tick;
    logic pll_tick;
    logic [9:0] lock_cnt;
    logic [7:0] rd_data;
  } ctl_state_t;

endpackage

// ===== rtl/main_clk_switch.sv
// Glitch-free switch of the main system clock enable between two sources.
`timescale 1ns/1ps
`include "clkctl_params.svh"
module main_clk_switch (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic want_pll_i,
  input wire logic base_tick_i,
  input wire logic pll_tick_i,
  output logic main_tick_o,
  output logic on_pll_o
);
  import clkctl_pkg::*;

  sw_state_t st_ff;
  sw_state_t nxt_st;
  logic old_tick;
  logic new_tick;

  always_comb begin
    nxt_st = st_ff;
    old_tick = st_ff.on_pll ? pll_tick_i : base_tick_i;
    new_tick = st_ff.want_pll ? pll_tick_i : base_tick_i;
    nxt_st.tick = 1'b0;
    case (st_ff.phase)
      SW_RUN: begin
        nxt_st.tick = old_tick;
        if (want_pll_i != st_ff.on_pll) begin
          nxt_st.want_pll = want_pll_i;
          nxt_st.phase = SW_DRAIN;
        end
      end
      // The old source finishes its period before the output goes quiet,
      // so no shortened pulse ever reaches the clock tree.
      SW_DRAIN: begin
        nxt_st.tick = old_tick;
        if (old_tick) begin
          nxt_st.phase = SW_WAIT_NEW;
        end
      end
      // The state flag moves only when the new source really drives.
      SW_WAIT_NEW: begin
        if (new_tick) begin
          nxt_st.on_pll = st_ff.want_pll;
          nxt_st.phase = SW_RUN;
        end
      end
      default: begin
        nxt_st.phase = SW_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_ff <= '{phase: SW_RUN, on_pll: 1'b0, want_pll: 1'b0, tick: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign main_tick_o = st_ff.tick;
  assign on_pll_o = st_ff.on_pll;

endmodule // main_clk_switch

// ===== tb/clock_ctrl_properties.sv
// Concurrent checks on the clock control block ports.
`timescale 1ns/1ps
`include "clkctl_params.svh"
module clock_ctrl_properties (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire clkctl_pkg::reg_req_t req_i,
  input wire logic [7:0] rd_data_o,
  input wire logic wdt_active_i,
  input wire logic pll_osc_tick_i,
  input wire logic hoco_run_o,
  input wire logic loco_run_o,
  input wire logic pll_run_o,
  input wire logic pll_ref_tick_o,
  input wire logic pll_factor_ok_o,
  input wire logic pll_lock_wait_o,
  input wire logic pll_tick_o,
  input wire logic main_on_pll_o
);
  import clkctl_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [9:0] wait_len_ff;
  // Counts consecutive lock-wait cycles so a stuck status shows up.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !pll_lock_wait_o) wait_len_ff <= 10'h000;
    else wait_len_ff <= wait_len_ff + 10'h001;
  end
  sequence s_lock_hold;
    pll_lock_wait_o [*8];
  endsequence
  property p_lock_rise;
    $rose(pll_run_o) |=> s_lock_hold;
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock wait low");
  property p_lock_len;
    wait_len_ff < 10'h192;
  endproperty
  a_lock_len: assert property (p_lock_len) else $error("lock wait long");
  property p_pll_out;
    pll_tick_o |-> $past(pll_run_o) && $past(pll_factor_ok_o)
      && $past(pll_osc_tick_i);
  endproperty
  a_pll_out: assert property (p_pll_out) else $error("pll tick bad");
  property p_ref_gap;
    pll_ref_tick_o |=> !pll_ref_tick_o [*5];
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("ref tick gap");
  property p_ref_run;
    pll_ref_tick_o |-> $past(pll_run_o);
  endproperty
  a_ref_run: assert property (p_ref_run) else $error("ref when stopped");
  property p_hoco_boot;
    $rose(rst_b_i) |-> hoco_run_o;
  endproperty
  a_hoco_boot: assert property (p_hoco_boot) else $error("hoco off");
  property p_loco_wdt;
    wdt_active_i |-> loco_run_o;
  endproperty
  a_loco_wdt: assert property (p_loco_wdt) else $error("loco off");
  property p_rd_idle;
    !$past(req_i.rd) |-> rd_data_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data idle");
  property p_main_rd;
    $past(req_i.rd) && $past(req_i.addr) == `CC_OFS_MAIN_CTRL |->
      rd_data_o[6:1] == 6'h00 && rd_data_o[7] == $past(main_on_pll_o);
  endproperty
  a_main_rd: assert property (p_main_rd) else $error("state bit");
endmodule // clock_ctrl_properties
bind clock_ctrl clock_ctrl_properties clock_ctrl_properties_i (.clk_i,
  .rst_b_i, .req_i, .rd_data_o, .wdt_active_i, .pll_osc_tick_i, .hoco_run_o,
  .loco_run_o, .pll_run_o, .pll_ref_tick_o, .pll_factor_ok_o,
  .pll_lock_wait_o, .pll_tick_o, .main_on_pll_o);

// ===== tb/clock_ctrl_tb.sv
// Self-checking testbench for the clock control block.
`timescale 1ns/1ps
`include "clkctl_params.svh"
module clock_ctrl_tb;
  import clkctl_pkg::*;
  logic clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  reg_req_t req_i = '0;
  logic hoco_tick_i = 1'h0, oco_tick_i = 1'h0, mx_tick_i = 1'h0;
  logic pll_osc_tick_i = 1'h0, wdt_active_i = 1'h0;
  logic [7:0] rd_data_o;
  logic hoco_run_o, moco_run_o, loco_run_o, pll_run_o, pll_ref_tick_o;
  logic pll_factor_ok_o, pll_lock_wait_o, pll_tick_o, main_tick_o;
  logic main_on_pll_o, dsad_tick_o;
  osc_mode_t main_osc_mode_o, sub_osc_mode_o;
  logic [3:0] ph_ff = 4'h0;
  int failures = 0, cmp_count = 0, cnt_v;
  clock_ctrl clock_ctrl_i (.clk_i, .rst_b_i, .req_i, .rd_data_o,
    .hoco_tick_i, .oco_tick_i, .mx_tick_i, .pll_osc_tick_i, .wdt_active_i,
    .hoco_run_o, .moco_run_o, .loco_run_o, .pll_run_o, .pll_ref_tick_o,
    .pll_factor_ok_o, .pll_lock_wait_o, .pll_tick_o, .main_tick_o,
    .main_on_pll_o, .dsad_tick_o, .main_osc_mode_o, .sub_osc_mode_o);
  always #50 clk_i = ~clk_i;
  // Oscillator enables: fast source every cycle, others at fixed fractions.
  always @(posedge clk_i) begin
    ph_ff <= ph_ff + 4'h1;
    hoco_tick_i <= 1'h1;
    oco_tick_i <= ph_ff[0];
    pll_osc_tick_i <= ~ph_ff[0];
    mx_tick_i <= ph_ff[1:0] == 2'h0;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk(n, {7'h0, e}, {7'h0, g});
  endtask
  // Strobes change only by non-blocking assignment on a rising edge.
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_i <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clk_i);
    req_i <= '0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] e, input string n);
    @(posedge clk_i);
    req_i <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clk_i);
    req_i <= '0;
    #1 chk(n, e, rd_data_o);
  endtask
  task automatic cnt(ref logic s, input int n);
    cnt_v = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1 cnt_v += s;
    end
  endtask
  task automatic t_reset;
    logic [19:0] a[10] = '{`CC_OFS_PERIPH_GATE, `CC_OFS_PLL_CTRL,
      `CC_OFS_MAIN_CTRL, `CC_OFS_MODE_CTRL, `CC_OFS_SUB_MODE,
      `CC_OFS_OSC_STATUS, `CC_OFS_SUBSYS_SEL, `CC_OFS_SYS_CTRL,
      `CC_OFS_SUPPLY_MODE, 20'h00000};
    foreach (a[i]) rd(a[i], 8'h00, "reset");
    chk1("hoco", 1'h1, hoco_run_o);
    chk1("on_pll", 1'h0, main_on_pll_o);
    wr(20'h00000, 8'hFF);
    rd(20'h00000, 8'h00, "unmapped");
  endtask
  task automatic t_pll;
    wr(`CC_OFS_PLL_CTRL, 8'h0C);
    chk1("fok", 1'h0, pll_factor_ok_o);
    wr(`CC_OFS_PLL_CTRL, 8'h0A);
    chk1("fok", 1'h0, pll_factor_ok_o);
    wr(`CC_OFS_PLL_CTRL, 8'h0E);
    chk1("fok", 1'h1, pll_factor_ok_o);
    wr(`CC_OFS_PLL_CTRL, 8'h0F);
    chk1("run", 1'h1, pll_run_o);
    chk1("lock", 1'h1, pll_lock_wait_o);
    rd(`CC_OFS_PLL_CTRL, 8'h0F, "pllctl");
    cnt(pll_ref_tick_o, 60);
    chk("ref_off", 8'h00, cnt_v[7:0]);
    wr(`CC_OFS_PERIPH_GATE, 8'h02);
    cnt(pll_ref_tick_o, 60);
    chk("ref_on", 8'h0A, cnt_v[7:0]);
    cnt(pll_tick_o, 20);
    chk("pll", 8'h0A, cnt_v[7:0]);
    repeat (400) @(posedge clk_i);
    #1 chk1("lock", 1'h0, pll_lock_wait_o);
  endtask
  task automatic t_switch;
    int i;
    wr(`CC_OFS_MAIN_CTRL, 8'h01);
    for (i = 0; i < 60 && main_on_pll_o !== 1'h1; i++) @(posedge clk_i);
    #1 chk1("on_pll", 1'h1, main_on_pll_o);
    rd(`CC_OFS_MAIN_CTRL, 8'h81, "main");
    cnt(main_tick_o, 20);
    chk("main_pll", 8'h0A, cnt_v[7:0]);
    cnt(dsad_tick_o, 40);
    chk("dsad_hoco", 8'h14, cnt_v[7:0]);
    wr(`CC_OFS_PERIPH_GATE, 8'h03);
    cnt(dsad_tick_o, 40);
    chk("dsad_mx", 8'h0A, cnt_v[7:0]);
    wr(`CC_OFS_SYS_CTRL, 8'h10);
    repeat (60) @(posedge clk_i);
    #1 chk1("on_pll", 1'h0, main_on_pll_o);
    cnt(main_tick_o, 20);
    chk("main_mx", 8'h05, cnt_v[7:0]);
    wr(`CC_OFS_SYS_CTRL, 8'h00);
    wr(`CC_OFS_MAIN_CTRL, 8'h00);
    repeat (60) @(posedge clk_i);
    #1 rd(`CC_OFS_MAIN_CTRL, 8'h00, "main");
    wr(`CC_OFS_PLL_CTRL, 8'h0E);
    cnt(pll_tick_o, 20);
    chk("pll_off", 8'h00, cnt_v[7:0]);
  endtask
  task automatic t_osc;
    wr(`CC_OFS_MODE_CTRL, 8'h50);
    wr(`CC_OFS_SUB_MODE, 8'h10);
    chk("mmode", {6'h0, OSC_RESONATOR}, {6'h0, main_osc_mode_o});
    chk("smode", {6'h0, OSC_RESONATOR}, {6'h0, sub_osc_mode_o});
    wr(`CC_OFS_MODE_CTRL, 8'hD0);
    wr(`CC_OFS_SUB_MODE, 8'h30);
    chk("mmode", {6'h0, OSC_EXT_CLOCK}, {6'h0, main_osc_mode_o});
    chk("smode", {6'h0, OSC_EXT_CLOCK}, {6'h0, sub_osc_mode_o});
    wr(`CC_OFS_MODE_CTRL, 8'h00);
    wr(`CC_OFS_SUB_MODE, 8'h00);
    chk("mmode", {6'h0, OSC_PORT}, {6'h0, main_osc_mode_o});
    chk("smode", {6'h0, OSC_PORT}, {6'h0, sub_osc_mode_o});
    wr(`CC_OFS_OSC_STATUS, 8'h03);
    chk1("hoco", 1'h0, hoco_run_o);
    chk1("moco", 1'h1, moco_run_o);
    wr(`CC_OFS_OSC_STATUS, 8'h00);
    chk1("moco", 1'h0, moco_run_o);
    chk1("loco", 1'h0, loco_run_o);
    wr(`CC_OFS_SUPPLY_MODE, 8'h10);
    chk1("loco", 1'h1, loco_run_o);
    wr(`CC_OFS_SUPPLY_MODE, 8'h00);
    wr(`CC_OFS_SUBSYS_SEL, 8'h01);
    chk1("loco", 1'h1, loco_run_o);
    wr(`CC_OFS_SUBSYS_SEL, 8'h00);
    @(posedge clk_i);
    wdt_active_i <= 1'h1;
    @(posedge clk_i);
    #1 chk1("loco", 1'h1, loco_run_o);
  endtask
  task automatic results;
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #500000;
    failures++;
    results;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'h1;
    @(posedge clk_i);
    #1;
    t_reset;
    t_pll;
    t_switch;
    t_osc;
    results;
  end
endmodule // clock_ctrl_tb
